// ### core/xb_ext_bus.sv
/*
 multiplexed external memory bus for an 8-bit core, with an ahb-lite
 register slave for its control bits.
 assumes one 100 mhz clock, the core's data port on that clock holding a
 request until done, and the external latch transparent while ale is high.
*/
// Register access over AHB-Lite and the placing of the registers were decided locally.
// Behaviour
// - legacy mode hides both extended control registers
// - legacy mode offers only wait codes 00, 01
// - legacy mode fixes high address width
// - legacy mode uses one region, one wait setting
// - legacy: no keeper, strobes and latch output-only
// - drive muxed low bus, high bus, strobes
// - enabled bus overrides pin directions
// - decode internal or external by address
// - low address valid at latch fall, latch low after
// - internal accesses move pins, strobes stay idle
// - disabled bus never folds high addresses inward
// - pull-ups follow port bits set to one
// - keeper holds last level when lines released
// - four wait settings, two sectors
// - upper and lower sectors own separate select bits
// - trailing latch in T4/T5 only if next accesses ram
// - trailing latch in T6/T7 only if next accesses ram
// - enable bit switches pins to bus function
// - wait codes 00, 01, 10, 11 with gap cycle
// - sector limit steps of 0x2000, code 000 single
// - high mask releases top high address pins
`timescale 1ns/1ns
`default_nettype none

module xb_ext_bus
	import xb_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire xb_req_t     req,
	output logic             req_done,
	output logic      [7:0]  req_rdata,
	input  wire logic [7:0]  ad_in,
	input  wire logic [7:0]  port_ad_val,
	input  wire logic [7:0]  port_ad_dir,
	input  wire logic [7:0]  port_hi_val,
	input  wire logic [7:0]  port_hi_dir,
	output xb_pins_t         pins,
	output logic      [7:0]  ad_pullup_en,
	output logic             ad_keep_en,
	output logic      [7:0]  ad_keep_val
);

	// ------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] sector_base(input logic [2:0] sel);
		sector_base = 16'({13'h0, sel} * `XB_SECTOR_STEP);
	endfunction

	function automatic logic [1:0] pick_wait(input logic legacy, input logic [7:0] cc,
		input logic [7:0] ca, input logic [15:0] a);
		logic [2:0] sel;
		logic [1:0] up;
		sel = ca[`XB_POS_SECTOR +: 3];
		up  = {ca[`XB_BIT_UP_WAIT_MSB], cc[`XB_BIT_UP_WAIT_LSB]};
		if (legacy)
			pick_wait = {1'b0, cc[`XB_BIT_UP_WAIT_LSB]};
		else if (sel == 3'h0 || a >= sector_base(sel))
			pick_wait = up;
		else
			pick_wait = ca[`XB_POS_LO_WAIT +: 2];
	endfunction

	// ------------------------------------------------------------
	// register slave
	// ------------------------------------------------------------
	logic [7:0]  core_ctrl_q, core_ctrl_d;
	logic [7:0]  ctrl_a_q,    ctrl_a_d;
	logic [7:0]  ctrl_b_q,    ctrl_b_d;
	logic        legacy_q,    legacy_d;
	logic        wr_pend_q,   wr_pend_d;
	logic [7:0]  wr_addr_q,   wr_addr_d;
	logic [31:0] rdata_q,     rdata_d;
	logic        busy;
	logic [7:0]  last_rd_q;
	logic        take;

	// zero wait states: read data is registered as the address phase is taken
	assign take      = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;

	always_comb begin
		core_ctrl_d = core_ctrl_q;
		ctrl_a_d    = ctrl_a_q;
		ctrl_b_d    = ctrl_b_q;
		legacy_d    = legacy_q;
		wr_pend_d   = take & hwrite;
		wr_addr_d   = take ? haddr[7:0] : wr_addr_q;
		rdata_d     = rdata_q;
		if (wr_pend_q) begin
			case (wr_addr_q)
				`XB_OFF_CORE_CTRL: core_ctrl_d = hwdata[7:0];
				// reserved bits of both extended registers hold zero
				`XB_OFF_CTRL_A: if (!legacy_q) ctrl_a_d = hwdata[7:0] & 8'h7e;
				`XB_OFF_CTRL_B: if (!legacy_q) ctrl_b_d = hwdata[7:0] & 8'h87;
				`XB_OFF_MODE:   legacy_d = hwdata[`XB_BIT_LEGACY];
				default: ;
			endcase
		end
		if (take && !hwrite) begin
			case (haddr[7:0])
				`XB_OFF_CORE_CTRL: rdata_d = {24'h0, core_ctrl_q};
				`XB_OFF_CTRL_A:    rdata_d = legacy_q ? 32'h0 : {24'h0, ctrl_a_q};
				`XB_OFF_CTRL_B:    rdata_d = legacy_q ? 32'h0 : {24'h0, ctrl_b_q};
				`XB_OFF_MODE:      rdata_d = {31'h0, legacy_q};
				`XB_OFF_STATUS:    rdata_d = {16'h0, last_rd_q, 7'h0, busy};
				default:           rdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_ctrl_q <= `XB_RST_CORE_CTRL;
			ctrl_a_q    <= `XB_RST_CTRL_A;
			ctrl_b_q    <= `XB_RST_CTRL_B;
			legacy_q    <= `XB_RST_LEGACY;
			wr_pend_q   <= 1'b0;
			wr_addr_q   <= 8'h00;
			rdata_q     <= 32'h0;
		end else begin
			core_ctrl_q <= core_ctrl_d;
			ctrl_a_q    <= ctrl_a_d;
			ctrl_b_q    <= ctrl_b_d;
			legacy_q    <= legacy_d;
			wr_pend_q   <= wr_pend_d;
			wr_addr_q   <= wr_addr_d;
			rdata_q     <= rdata_d;
		end
	end

	// ------------------------------------------------------------
	// effective configuration
	// ------------------------------------------------------------
	logic        bus_en;
	logic        keeper_on;
	logic [2:0]  hi_mask;
	logic [15:0] int_top;

	assign bus_en    = core_ctrl_q[`XB_BIT_BUS_EN];
	// extended features vanish in legacy mode, even if bits were set before
	assign keeper_on = ctrl_b_q[`XB_BIT_KEEPER] & ~legacy_q;
	assign hi_mask   = legacy_q ? 3'h0 : ctrl_b_q[`XB_POS_HI_MASK +: 3];
	// legacy mode shrinks the internal space, so externals start lower
	assign int_top   = legacy_q ? `XB_INT_TOP_LEGACY : `XB_INT_TOP_NORMAL;

	// ------------------------------------------------------------
	// pin input synchroniser
	// ------------------------------------------------------------
	// pads are not timed to hclk, so reads go through two flops
	// read data therefore lags the pads by two cycles
	logic [7:0] ad_s1_q, ad_s2_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ad_s1_q <= 8'h00;
			ad_s2_q <= 8'h00;
		end else begin
			ad_s1_q <= ad_in;
			ad_s2_q <= ad_s1_q;
		end
	end

	// ------------------------------------------------------------
	// access sequencer
	// ------------------------------------------------------------
	xb_state_t   st_q, st_d;
	logic [1:0]  code_q, code_d;
	logic [1:0]  cnt_q, cnt_d;
	logic        ext_q, ext_d;
	logic        wr_q, wr_d;
	logic        nram_q, nram_d;
	logic [15:0] addr_q, addr_d;
	logic [7:0]  wd_q, wd_d;
	logic [7:0]  last_rd_d;
	logic [7:0]  keep_q, keep_d;

	// one request at a time; a new one waits for idle
	assign busy = (st_q != XB_IDLE);

	always_comb begin
		st_d      = st_q;
		code_d    = code_q;
		cnt_d     = cnt_q;
		ext_d     = ext_q;
		wr_d      = wr_q;
		nram_d    = nram_q;
		addr_d    = addr_q;
		wd_d      = wd_q;
		last_rd_d = last_rd_q;
		case (st_q)
			XB_IDLE: if (req.valid) begin
				addr_d = req.addr;
				wd_d   = req.wdata;
				wr_d   = req.write;
				nram_d = req.next_ram;
				ext_d  = bus_en & (req.addr >= int_top);
				code_d = pick_wait(legacy_q, core_ctrl_q, ctrl_a_q, req.addr);
				// disabled bus: no external cycle and no fold into sram
				st_d   = bus_en ? XB_ADDR : XB_DONE;
			end
			XB_ADDR: begin
				cnt_d = (code_q > `XB_WAIT_MAX) ? `XB_WAIT_MAX : code_q;
				st_d  = XB_STRB;
			end
			XB_STRB: begin
				if (cnt_q == 2'h0) begin
					st_d = XB_HOLD;
				end else begin
					cnt_d = cnt_q - 2'h1;
				end
			end
			XB_HOLD: begin
				// the sync output now shows the pads two cycles back, so under codes
				// 10, 11 a slow part gets the first strobe cycle to settle; code 00
				// reads see the address cycle, code 01 reads the first strobe cycle
				if (ext_q && !wr_q)
					last_rd_d = ad_s2_q;
				if (code_q == `XB_WAIT_GAP_CODE)
					st_d = XB_GAP;
				else
					st_d = nram_q ? XB_TRAIL : XB_DONE;
			end
			XB_GAP:   st_d = nram_q ? XB_TRAIL : XB_DONE;
			XB_TRAIL: st_d = XB_DONE;
			XB_DONE:  st_d = XB_IDLE;
			default:  st_d = XB_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q      <= XB_IDLE;
			code_q    <= 2'h0;
			cnt_q     <= 2'h0;
			ext_q     <= 1'b0;
			wr_q      <= 1'b0;
			nram_q    <= 1'b0;
			addr_q    <= 16'h0;
			wd_q      <= 8'h00;
			last_rd_q <= 8'h00;
		end else begin
			st_q      <= st_d;
			code_q    <= code_d;
			cnt_q     <= cnt_d;
			ext_q     <= ext_d;
			wr_q      <= wr_d;
			nram_q    <= nram_d;
			addr_q    <= addr_d;
			wd_q      <= wd_d;
			last_rd_q <= last_rd_d;
		end
	end

	assign req_done  = (st_q == XB_DONE);
	assign req_rdata = last_rd_q;

	// ------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------
	// internal accesses still run the pin sequence, only strobes stay quiet
	logic drive_addr, drive_data, strobe;

	assign drive_addr = (st_q == XB_ADDR) | (st_q == XB_TRAIL);
	assign drive_data = wr_q & ((st_q == XB_STRB) | (st_q == XB_HOLD));
	assign strobe     = ext_q & (st_q == XB_STRB);

	always_comb begin
		pins.ale      = (st_q == XB_ADDR) | (st_q == XB_TRAIL);
		pins.rd_n     = ~(strobe & ~wr_q);
		pins.wr_n     = ~(strobe & wr_q);
		// in legacy mode the strobe and latch pins are never inputs
		pins.ctl_oe_n = ~(bus_en | legacy_q);
		if (bus_en) begin
			// address stays on ad until the latch falls
			pins.ad_out  = drive_addr ? addr_q[7:0] : wd_q;
			pins.ad_oe_n = {8{~(drive_addr | drive_data)}};
		end else begin
			pins.ad_out  = port_ad_val;
			pins.ad_oe_n = ~port_ad_dir;
		end
		for (int i = 0; i < 8; i++) begin
			if (bus_en && (i < 8 - int'(hi_mask))) begin
				pins.hi_out[i]  = addr_q[8 + i];
				pins.hi_oe_n[i] = 1'b0;
			end else begin
				pins.hi_out[i]  = port_hi_val[i];
				pins.hi_oe_n[i] = ~port_hi_dir[i];
			end
		end
	end

	// pull-ups only matter while nobody drives the pad
	assign ad_pullup_en = port_ad_val & pins.ad_oe_n;

	// ------------------------------------------------------------
	// bus keeper
	// ------------------------------------------------------------
	// keeper level follows what was last driven or seen on the pads
	// while off it tracks the pads, so switching it on holds a fresh level
	always_comb begin
		keep_d = keep_q;
		if (pins.ad_oe_n == 8'h00)
			keep_d = pins.ad_out;
		else if (!keeper_on)
			keep_d = ad_s2_q;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			keep_q <= 8'h00;
		else
			keep_q <= keep_d;
	end

	assign ad_keep_en  = keeper_on & (pins.ad_oe_n != 8'h00);
	assign ad_keep_val = keep_q;

endmodule

`default_nettype wire

// ### include/xb_cfg.svh
/*
 external bus interface constants: register offsets, field positions,
 reset values and address boundaries.
 assumes inclusion by bare name from the package and the bench.
*/
`ifndef XB_CFG_SVH
`define XB_CFG_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define XB_OFF_CORE_CTRL   8'h00
`define XB_OFF_CTRL_A      8'h04
`define XB_OFF_CTRL_B      8'h08
`define XB_OFF_MODE        8'h0c
`define XB_OFF_STATUS      8'h10

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define XB_BIT_BUS_EN      7
`define XB_BIT_UP_WAIT_LSB 6
`define XB_BIT_UP_WAIT_MSB 1
`define XB_POS_LO_WAIT     2
`define XB_POS_SECTOR      4
`define XB_BIT_KEEPER      7
`define XB_POS_HI_MASK     0
`define XB_BIT_LEGACY      0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define XB_RST_CORE_CTRL   8'h00
`define XB_RST_CTRL_A      8'h00
`define XB_RST_CTRL_B      8'h00
`define XB_RST_LEGACY      1'b0

// ------------------------------------------------------------
// address map and wait code limits
// ------------------------------------------------------------
`define XB_INT_TOP_NORMAL  16'h1100
`define XB_INT_TOP_LEGACY  16'h1000
`define XB_SECTOR_STEP     16'h2000
`define XB_WAIT_MAX        2'h2
`define XB_WAIT_GAP_CODE   2'h3

`endif

// ### include/xb_pkg.sv
/*
 external bus interface types.
 assumes xb_cfg.svh on the include path.
*/
package xb_pkg;
	`include "xb_cfg.svh"

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        next_ram;
	} xb_req_t;

	typedef struct packed {
		logic [7:0] ad_out;
		logic [7:0] ad_oe_n;
		logic [7:0] hi_out;
		logic [7:0] hi_oe_n;
		logic       ale;
		logic       rd_n;
		logic       wr_n;
		logic       ctl_oe_n;
	} xb_pins_t;

	typedef enum logic [2:0] {
		XB_IDLE, XB_ADDR, XB_STRB, XB_HOLD, XB_GAP, XB_TRAIL, XB_DONE
	} xb_state_t;
endpackage

// ### tb/xb_ext_bus_bench.sv
/*
 self-checking bench for xb_ext_bus with the sram model.
 assumes monitor and model compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "xb_cfg.svh"
module xb_ext_bus_bench import xb_pkg::*;;
	logic        hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout, req_done, ad_keep_en;
	logic        slow;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [7:0]  req_rdata, ad_in, port_ad_val, port_ad_dir, port_hi_val, port_hi_dir;
	logic [7:0]  ad_pullup_en, ad_keep_val, hi;
	xb_req_t     req;
	xb_pins_t    pins;
	int          err_total, tests_run, seed, n;
	logic [15:0] a [4];
	logic [7:0]  d [4];
	xb_ext_bus u_xb_ext_bus (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.hsel         (hsel),
		.haddr        (haddr),
		.htrans       (htrans),
		.hwrite       (hwrite),
		.hsize        (hsize),
		.hwdata       (hwdata),
		.hready       (hready),
		.hrdata       (hrdata),
		.hreadyout    (hreadyout),
		.hresp        (hresp),
		.req          (req),
		.req_done     (req_done),
		.req_rdata    (req_rdata),
		.ad_in        (ad_in),
		.port_ad_val  (port_ad_val),
		.port_ad_dir  (port_ad_dir),
		.port_hi_val  (port_hi_val),
		.port_hi_dir  (port_hi_dir),
		.pins         (pins),
		.ad_pullup_en (ad_pullup_en),
		.ad_keep_en   (ad_keep_en),
		.ad_keep_val  (ad_keep_val)
	);
	xb_sram_model u_xb_sram_model (.hclk(hclk), .slow(slow), .pins(pins), .ad_in(ad_in));
	assign hready = hreadyout;
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// ----
	// tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] o, input logic [31:0] wd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, o};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic cfg(input logic en, input logic [1:0] up, input logic [1:0] lo,
		input logic [2:0] sec);
		bus(1'b1, `XB_OFF_CORE_CTRL, {24'h0, en, up[0], 6'h0});
		bus(1'b1, `XB_OFF_CTRL_A, {25'h0, sec, lo, up[1], 1'b0});
	endtask
	task automatic xfer(input logic w, input logic [15:0] ad, input logic [7:0] wd, input logic nr);
		@(posedge hclk);
		req <= '{1'b1, w, ad, wd, nr};
		n = 0;
		do begin
			@(negedge hclk);
			n++;
			if (pins.ale === 1'b1 && n < 3)
				hi = pins.hi_out;
		end while (req_done !== 1'b1 && n < 40);
		@(posedge hclk);
		req <= '0;
	endtask
	function automatic int lat(input logic [1:0] c, input logic nr);
		return 5 + ((c > 2'h1) ? 2 : int'(c)) + int'(c == 2'h3) + int'(nr);
	endfunction
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----
	// sequence
	// ----
	initial begin
		seed = 71234;
		err_total = 0;
		tests_run = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		req = '0;
		slow = 1'b0;
		port_ad_val = 8'($random(seed));
		port_hi_val = 8'($random(seed));
		port_ad_dir = 8'hff;
		port_hi_dir = 8'hff;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, `XB_OFF_CTRL_A, 0);
		chk("ctrl_a reset", 0, rd);
		bus(1'b1, 8'h20, 32'hff);
		bus(1'b0, 8'h20, 0);
		chk("unmapped", 0, rd);
		$display("test registers done");
		for (int c = 0; c < 4; c++) begin
			cfg(1'b1, c[1:0], 2'h0, 3'h0);
			a[c] = {c[3:0] + 4'h4, 12'($random(seed))};
			d[c] = 8'($random(seed));
			xfer(1'b1, a[c], d[c], c[0]);
			chk("write cycles", lat(c[1:0], c[0]), n);
			chk("high byte", a[c][15:8], hi);
		end
		cfg(1'b1, 2'h2, 2'h0, 3'h0);
		for (int c = 0; c < 4; c++) begin
			slow <= c[0];
			xfer(1'b0, a[c], 0, 1'b0);
			chk("read byte", d[c], req_rdata);
		end
		bus(1'b0, `XB_OFF_STATUS, 0);
		chk("status", {16'h0, d[3], 8'h00}, rd);
		$display("test wait codes done");
		cfg(1'b1, 2'h3, 2'h0, 3'h1);
		xfer(1'b1, 16'h1fff, 8'h5a, 1'b0);
		chk("lower sector", lat(2'h0, 1'b0), n);
		xfer(1'b1, 16'h2000, 8'ha5, 1'b0);
		chk("upper sector", lat(2'h3, 1'b0), n);
		bus(1'b1, `XB_OFF_CTRL_B, 32'h7);
		xfer(1'b1, 16'h3456, 8'h11, 1'b1);
		chk("released high pins", port_hi_val, hi);
		xfer(1'b0, 16'h0800, 0, 1'b0);
		chk("bus pins driven", 0, pins.ctl_oe_n);
		$display("test sectors done");
		bus(1'b1, `XB_OFF_CTRL_B, 32'h80);
		cfg(1'b0, 2'h0, 2'h0, 3'h0);
		port_ad_dir <= 8'h00;
		xfer(1'b0, 16'h1100, 0, 1'b0);
		chk("keeper on", 1, ad_keep_en);
		chk("keeper level", port_ad_val, ad_keep_val);
		chk("pull-ups", port_ad_val, ad_pullup_en);
		chk("no fold", d[3], req_rdata);
		chk("pins follow port", {8'h00, port_ad_val}, {pins.ad_oe_n ^ 8'hff, pins.ad_out});
		$display("test disabled done");
		port_ad_dir <= 8'hff;
		cfg(1'b1, 2'h3, 2'h0, 3'h1);
		bus(1'b1, `XB_OFF_CTRL_B, 32'h87);
		bus(1'b1, `XB_OFF_MODE, 32'h1);
		bus(1'b0, `XB_OFF_CTRL_B, 0);
		chk("ctrl_b hidden", 0, rd);
		xfer(1'b1, 16'h1fff, 8'h3c, 1'b0);
		chk("legacy wait", lat(2'h1, 1'b0), n);
		chk("legacy high byte", 8'h1f, hi);
		chk("legacy keeper", 0, ad_keep_en);
		chk("legacy ctl driven", 0, pins.ctl_oe_n);
		$display("test legacy done");
		complete_run();
	end
	// the whole run takes well under 2000 cycles
	initial begin
		#200000;
		err_total++;
		complete_run();
	end
endmodule
`default_nettype wire

// ### tb/xb_ext_bus_monitor.sv
/*
 pin checker for the external bus.
 assumes bind onto xb_ext_bus, one clock.
*/
`timescale 1ns/1ns
`default_nettype none
module xb_ext_bus_monitor
	import xb_pkg::*;
(
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire xb_req_t    req,
	input wire logic       req_done,
	input wire xb_pins_t   pins,
	input wire logic [7:0] port_ad_val,
	input wire logic [7:0] ad_pullup_en
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ----
	// properties
	// ----
	sequence s_strb; !pins.rd_n || !pins.wr_n; endsequence
	sequence s_end; $rose(pins.rd_n & pins.wr_n) && !req.next_ram; endsequence
	property p_one_strb; !(!pins.rd_n && !pins.wr_n); endproperty
	property p_pull; ad_pullup_en == (port_ad_val & pins.ad_oe_n); endproperty
	// trailing latch falls in done, it repeats the low address just used
	property p_ale_fall; $fell(pins.ale) && !req_done |-> $past(pins.ad_out) == req.addr[7:0];
	endproperty
	property p_int; req.valid && req.addr < 16'h1000 |-> pins.rd_n && pins.wr_n; endproperty
	property p_len; $fell(pins.rd_n) |-> ##[1:3] pins.rd_n; endproperty
	property p_ale_low; s_strb |-> !pins.ale; endproperty
	property p_idle; !req.valid |-> pins.rd_n && pins.wr_n; endproperty
	property p_trail; s_end |-> !pins.ale [*3]; endproperty
	a_one_strb: assert property (p_one_strb) else $error("both strobes low");
	a_pull: assert property (p_pull) else $error("pull-up enable wrong");
	a_ale_fall: assert property (p_ale_fall) else $error("no address at latch fall");
	a_int: assert property (p_int) else $error("strobe on internal access");
	a_len: assert property (p_len) else $error("read strobe too long");
	a_ale_low: assert property (p_ale_low) else $error("latch high in strobe");
	a_idle: assert property (p_idle) else $error("strobe without access");
	a_trail: assert property (p_trail) else $error("trailing latch unasked");
endmodule
bind xb_ext_bus xb_ext_bus_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .req(req),
	.req_done(req_done), .pins(pins), .port_ad_val(port_ad_val), .ad_pullup_en(ad_pullup_en));
`default_nettype wire

// ### tb/xb_sram_model.sv
/*
 external sram behind a transparent address latch.
 assumes the pin struct of xb_ext_bus.
*/
`timescale 1ns/1ns
`default_nettype none
module xb_sram_model
	import xb_pkg::*;
(
	input  wire logic     hclk,
	input  wire logic     slow,
	input  wire xb_pins_t pins,
	output logic [7:0]    ad_in
);
	logic [7:0]  mem [0:65535];
	logic [15:0] lat_q;
	logic [7:0]  last_q = 8'h00;
	logic        fresh_q;
	// ----
	// latch, array, data drive
	// ----
	always_latch if (pins.ale) lat_q <= {pins.hi_out, pins.ad_out};
	// write taken on the strobe edge, no clock phase assumed
	always @(posedge pins.wr_n) mem[lat_q] <= pins.ad_out;
	always @(posedge hclk) begin
		fresh_q <= pins.rd_n;
		last_q  <= ad_in;
	end
	// slow part misses the first strobe cycle; released lines toggle
	assign ad_in = (!pins.rd_n && !(slow && fresh_q)) ? mem[lat_q] : ~last_q;
endmodule
`default_nettype wire
